// file: qstat_pkg.sv
// shared constants for the questionable and user status register sets
package qstat_pkg;
  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int REG_W = 15;
  localparam int ADDR_W = 8;
  localparam logic [14:0] RST_ZERO = 15'h0000;
  // ----------------------------------------------------------------
  // byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_QD_PTR = 8'h00;
  localparam logic [7:0] OFS_QD_NTR = 8'h04;
  localparam logic [7:0] OFS_QD_COND = 8'h08;
  localparam logic [7:0] OFS_QD_EVENT = 8'h0c;
  localparam logic [7:0] OFS_QP_COND = 8'h10;
  localparam logic [7:0] OFS_QP_ENABLE = 8'h14;
  localparam logic [7:0] OFS_QP_EVENT = 8'h18;
  localparam logic [7:0] OFS_QP_PTR = 8'h1c;
  localparam logic [7:0] OFS_QP_NTR = 8'h20;
  localparam logic [7:0] OFS_USR_ENABLE = 8'h24;
  localparam logic [7:0] OFS_USR_EVENT = 8'h28;
  localparam logic [7:0] OFS_USR_PULSE = 8'h2c;
  // ----------------------------------------------------------------
  // write data fields: bound keyword select
  // ----------------------------------------------------------------
  localparam int BOUND_FLAG_BIT = 31;
  localparam int BOUND_MAX_BIT = 30;
endpackage

// file: qstat_regs.sv
// apb register bank for questionable data, questionable power and user status sets
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/100ps

module qstat_regs #(
  parameter int W = qstat_pkg::REG_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qstat_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [W-1:0] qdata_cond_in,
  input wire logic [W-1:0] qpow_cond_in,
  input wire logic preset,
  output logic [W-1:0] user_cond,
  output logic qpow_summary,
  output logic user_summary
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // keyword bits must sit above the value field, or numbers would alias them
  if (W < 1 || W > qstat_pkg::BOUND_MAX_BIT) begin : g_bad_width
    $error("qstat_regs: W must lie in 1..30");
  end
  // every offset of the map must fit the address port
  if (qstat_pkg::ADDR_W < 6) begin : g_bad_addr
    $error("qstat_regs: address port too narrow for the register map");
  end

  localparam logic [W-1:0] VAL_MAX = {W{1'b1}};
  localparam logic [W-1:0] VAL_MIN = '0;
  // reset value cut or widened to the register width on purpose
  localparam logic [W-1:0] RST_VAL = W'(qstat_pkg::RST_ZERO);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // plain value or keyword substitution
  function automatic logic [W-1:0] set_value(input logic [31:0] wd);
    logic [W-1:0] v;
    v = wd[W-1:0];
    if (wd[qstat_pkg::BOUND_FLAG_BIT]) begin
      v = wd[qstat_pkg::BOUND_MAX_BIT] ? VAL_MAX : VAL_MIN;
    end
    return v;
  endfunction

  // numbers beyond the legal range are refused, keywords never are
  function automatic logic value_ok(input logic [31:0] wd);
    logic ok;
    ok = wd[qstat_pkg::BOUND_FLAG_BIT] || (wd[31:W] == '0);
    return ok;
  endfunction

  // events from filtered transitions
  function automatic logic [W-1:0] edge_events(input logic [W-1:0] now, input logic [W-1:0] prev,
                                               input logic [W-1:0] ptr, input logic [W-1:0] ntr);
    logic [W-1:0] rise;
    logic [W-1:0] fall;
    logic [W-1:0] e;
    rise = now & ~prev & ptr;
    fall = ~now & prev & ntr;
    e = rise | fall;
    return e;
  endfunction

  // read-clear keeps any bit that was not in the reported word
  function automatic logic [W-1:0] read_clear(input logic [W-1:0] evt, input logic sel,
                                              input logic [W-1:0] seen);
    logic [W-1:0] r;
    r = sel ? (evt & ~seen) : evt;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // condition input synchronisers
  // ----------------------------------------------------------------
  // a change counts only once stages two and three agree
  // the accepted value sits in the fourth flop, the one before it in the fifth
  logic [W-1:0] qd_s1_q, qd_s2_q, qd_s3_q, qd_cond_q, qd_prev_q;
  logic [W-1:0] qp_s1_q, qp_s2_q, qp_s3_q, qp_cond_q, qp_prev_q;
  logic [W-1:0] qd_cond_d, qp_cond_d;

  always_comb begin
    qd_cond_d = (qd_s2_q == qd_s3_q) ? qd_s3_q : qd_cond_q;
    qp_cond_d = (qp_s2_q == qp_s3_q) ? qp_s3_q : qp_cond_q;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      qd_s1_q <= '0;
      qd_s2_q <= '0;
      qd_s3_q <= '0;
      qd_cond_q <= '0;
      qd_prev_q <= '0;
      qp_s1_q <= '0;
      qp_s2_q <= '0;
      qp_s3_q <= '0;
      qp_cond_q <= '0;
      qp_prev_q <= '0;
    end else begin
      qd_s1_q <= qdata_cond_in;
      qd_s2_q <= qd_s1_q;
      qd_s3_q <= qd_s2_q;
      qd_cond_q <= qd_cond_d;
      qd_prev_q <= qd_cond_q;
      qp_s1_q <= qpow_cond_in;
      qp_s2_q <= qp_s1_q;
      qp_s3_q <= qp_s2_q;
      qp_cond_q <= qp_cond_d;
      qp_prev_q <= qp_cond_q;
    end
  end

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // one wait state so read data and error come from flip-flops
  logic ready_q, ready_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic wr_done, rd_done;
  logic hit;
  logic [W-1:0] rd_val;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [W-1:0] qd_ptr_q, qd_ntr_q, qd_evt_q;
  logic [W-1:0] qp_en_q, qp_ptr_q, qp_ntr_q, qp_evt_q;
  logic [W-1:0] usr_en_q, usr_evt_q, usr_cond_q;
  logic [W-1:0] qd_ptr_d, qd_ntr_d, qd_evt_d;
  logic [W-1:0] qp_en_d, qp_ptr_d, qp_ntr_d, qp_evt_d;
  logic [W-1:0] usr_en_d, usr_evt_d, usr_cond_d;
  logic [W-1:0] wval;
  logic wok;

  // ----------------------------------------------------------------
  // transfer completion
  // ----------------------------------------------------------------
  assign wr_done = psel && penable && ready_q && pwrite;
  assign rd_done = psel && penable && ready_q && !pwrite;

  // ----------------------------------------------------------------
  // read data decode
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    rd_val = '0;
    case (paddr)
      qstat_pkg::OFS_QD_PTR: rd_val = qd_ptr_q;
      qstat_pkg::OFS_QD_NTR: rd_val = qd_ntr_q;
      qstat_pkg::OFS_QD_COND: rd_val = qd_cond_q;
      qstat_pkg::OFS_QD_EVENT: rd_val = qd_evt_q;
      qstat_pkg::OFS_QP_COND: rd_val = qp_cond_q;
      qstat_pkg::OFS_QP_ENABLE: rd_val = qp_en_q;
      qstat_pkg::OFS_QP_EVENT: rd_val = qp_evt_q;
      qstat_pkg::OFS_QP_PTR: rd_val = qp_ptr_q;
      qstat_pkg::OFS_QP_NTR: rd_val = qp_ntr_q;
      qstat_pkg::OFS_USR_ENABLE: rd_val = usr_en_q;
      qstat_pkg::OFS_USR_EVENT: rd_val = usr_evt_q;
      qstat_pkg::OFS_USR_PULSE: rd_val = '0;
      default: hit = 1'b0;
    endcase
    wval = set_value(pwdata);
    wok = value_ok(pwdata);
  end

  always_comb begin
    ready_d = 1'b0;
    rdata_d = rdata_q;
    err_d = err_q;
    if (psel && penable && !ready_q) begin
      ready_d = 1'b1;
      rdata_d = pwrite ? 32'h0000_0000 : {{(32 - W){1'b0}}, rd_val};
      err_d = !hit || (pwrite && !wok);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign pready = ready_q;
  assign prdata = rdata_q;
  assign pslverr = ready_q && err_q;

  // ----------------------------------------------------------------
  // register updates
  // ----------------------------------------------------------------
  // read-clear drops only the bits that were reported, so an event
  // arriving between capture and completion survives
  always_comb begin
    logic wr_ok;
    logic [W-1:0] seen;
    logic [W-1:0] usr_set;
    // a refused write leaves every register as it was
    wr_ok = wr_done && !err_q;
    seen = rdata_q[W-1:0];
    // user set has no filters: the rising edge of a pulse latches
    usr_set = usr_cond_q;
    qd_ptr_d = qd_ptr_q;
    qd_ntr_d = qd_ntr_q;
    qp_en_d = qp_en_q;
    qp_ptr_d = qp_ptr_q;
    qp_ntr_d = qp_ntr_q;
    usr_en_d = usr_en_q;
    usr_cond_d = '0;
    qd_evt_d = qd_evt_q;
    qp_evt_d = qp_evt_q;
    usr_evt_d = usr_evt_q;
    if (wr_ok) begin
      case (paddr)
        qstat_pkg::OFS_QD_PTR: qd_ptr_d = wval;
        qstat_pkg::OFS_QD_NTR: qd_ntr_d = wval;
        qstat_pkg::OFS_QP_ENABLE: qp_en_d = wval;
        qstat_pkg::OFS_QP_PTR: qp_ptr_d = wval;
        qstat_pkg::OFS_QP_NTR: qp_ntr_d = wval;
        qstat_pkg::OFS_USR_ENABLE: usr_en_d = wval;
        qstat_pkg::OFS_USR_PULSE: usr_cond_d = wval;
        default: usr_cond_d = '0;
      endcase
    end
    qd_evt_d = read_clear(qd_evt_d, rd_done && paddr == qstat_pkg::OFS_QD_EVENT, seen);
    qp_evt_d = read_clear(qp_evt_d, rd_done && paddr == qstat_pkg::OFS_QP_EVENT, seen);
    usr_evt_d = read_clear(usr_evt_d, rd_done && paddr == qstat_pkg::OFS_USR_EVENT, seen);
    if (preset) begin
      // enables and filters deliberately untouched
      qd_evt_d = '0;
      qp_evt_d = '0;
      usr_evt_d = '0;
    end
    // set wins over any clear in the same cycle
    qd_evt_d = qd_evt_d | edge_events(qd_cond_q, qd_prev_q, qd_ptr_q, qd_ntr_q);
    qp_evt_d = qp_evt_d | edge_events(qp_cond_q, qp_prev_q, qp_ptr_q, qp_ntr_q);
    usr_evt_d = usr_evt_d | usr_set;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      qd_ptr_q <= RST_VAL;
      qd_ntr_q <= RST_VAL;
      qd_evt_q <= RST_VAL;
      qp_en_q <= RST_VAL;
      qp_ptr_q <= RST_VAL;
      qp_ntr_q <= RST_VAL;
      qp_evt_q <= RST_VAL;
      usr_en_q <= RST_VAL;
      usr_evt_q <= RST_VAL;
      usr_cond_q <= RST_VAL;
    end else begin
      qd_ptr_q <= qd_ptr_d;
      qd_ntr_q <= qd_ntr_d;
      qd_evt_q <= qd_evt_d;
      qp_en_q <= qp_en_d;
      qp_ptr_q <= qp_ptr_d;
      qp_ntr_q <= qp_ntr_d;
      qp_evt_q <= qp_evt_d;
      usr_en_q <= usr_en_d;
      usr_evt_q <= usr_evt_d;
      usr_cond_q <= usr_cond_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign user_cond = usr_cond_q;
  assign qpow_summary = |(qp_evt_q & qp_en_q);
  assign user_summary = |(usr_evt_q & usr_en_q);

endmodule

// file: qstat_regs_assertions.sv
// port-level assertion checker for the status register bank
`timescale 1ns/100ps
module qstat_regs_assertions #(
  parameter int W = qstat_pkg::REG_W
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qstat_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic preset,
  input wire logic [W-1:0] user_cond,
  input wire logic user_summary
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // capture edge and completed pulse write, kept as plain nets
  wire logic cap = psel && penable && !pready;
  wire logic pdone = psel && penable && pready && pwrite && !pslverr && paddr == qstat_pkg::OFS_USR_PULSE;
  chk_ready_answer: assert property (cap |=> pready) else $error("no ready after capture");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_range_err: assert property (cap && pwrite && !pwdata[31] && pwdata[30:15] != '0 |=> pslverr)
    else $error("out of range write not refused");
  chk_read_width: assert property (pready && !pwrite |-> prdata[31:W] == '0) else $error("read bits high");
  chk_pulse_value: assert property (pdone && !pwdata[31] |=> {{(32 - W){1'b0}}, user_cond} == $past(pwdata))
    else $error("pulse bits wrong");
  chk_pulse_max: assert property (pdone && pwdata[31] && pwdata[30] |=> user_cond == '1)
    else $error("max pulse wrong");
  chk_pulse_width: assert property (user_cond != '0 |=> user_cond == '0) else $error("pulse too long");
  chk_pulse_cause: assert property (user_cond != '0 |-> $past(pdone)) else $error("pulse without write");
  chk_preset_user: assert property (preset && user_cond == '0 |=> !user_summary)
    else $error("user summary after preset");
endmodule

bind qstat_regs qstat_regs_assertions #(.W(W)) u_chk (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .preset, .user_cond, .user_summary);

// file: qstat_cond_src.sv
// condition source standing in for the monitored instrument signals
`timescale 1ns/100ps
module qstat_cond_src #(
  parameter int W = 15
) (
  input wire logic core_clk,
  input wire logic [W-1:0] data_req,
  input wire logic [W-1:0] pow_req,
  output logic [W-1:0] qdata_cond_in,
  output logic [W-1:0] qpow_cond_in
);
  initial begin
    qdata_cond_in = '0;
    qpow_cond_in = '0;
  end
  // steps land just after an edge, so no glitch reaches the synchronisers
  always @(posedge core_clk) begin
    qdata_cond_in <= data_req;
    qpow_cond_in <= pow_req;
  end
endmodule

// file: questionable_user_status_sets_test.sv
// self-checking apb bench for the status register bank
`timescale 1ns/100ps
module questionable_user_status_sets_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, preset = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, qpow_summary, user_summary;
  logic [14:0] user_cond, qd_c, qp_c, data_req = 15'h0000, pow_req = 15'h0000;
  logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h14, 8'h1c, 8'h20, 8'h24};
  int error_cnt = 0;
  int num_checks = 0;
  always #5 core_clk = ~core_clk;
  qstat_cond_src SRC (.core_clk, .data_req, .pow_req, .qdata_cond_in(qd_c), .qpow_cond_in(qp_c));
  qstat_regs DUT (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .qdata_cond_in(qd_c), .qpow_cond_in(qp_c), .preset, .user_cond, .qpow_summary, .user_summary);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one transfer; request held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic [31:0] d, input logic w, input logic e, input logic [31:0] x);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwdata <= d;
    pwrite <= w;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    check("err", {31'h0, e}, {31'h0, pslverr});
    if (!w) check("rdata", x, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, d, 1'b1, 1'b0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(a, 32'h0, 1'b0, 1'b0, x);
  endtask
  task automatic pre();
    preset <= 1'b1;
    @(posedge core_clk);
    preset <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 13; i++) xfer(8'(i * 4), 32'h0, 1'b0, i == 12, 32'h0);
    foreach (offs[i]) begin
      wr(offs[i], 32'h7fff - i);
      rd(offs[i], 32'h7fff - i);
      xfer(offs[i], 32'h8000, 1'b1, 1'b1, 32'h0);
      rd(offs[i], 32'h7fff - i);
      wr(offs[i], 32'h8000_0000);
      rd(offs[i], 32'h0);
      wr(offs[i], 32'hc000_0000);
      rd(offs[i], 32'h7fff);
      wr(offs[i], 32'h1 << i);
    end
    pre();
    foreach (offs[i]) rd(offs[i], 32'h1 << i);
    pow_req <= 15'h0018;
    data_req <= 15'h0001;
    repeat (8) @(posedge core_clk);
    rd(8'h10, 32'h18);
    rd(8'h10, 32'h18);
    check("pow_sum", 32'h0, qpow_summary);
    rd(8'h0c, 32'h1);
    wr(8'h14, 32'h8);
    check("pow_sum", 32'h1, qpow_summary);
    rd(8'h18, 32'h8);
    rd(8'h18, 32'h0);
    check("pow_sum", 32'h0, qpow_summary);
    pow_req <= 15'h0000;
    data_req <= 15'h0000;
    repeat (8) @(posedge core_clk);
    rd(8'h18, 32'h10);
    rd(8'h0c, 32'h0);
    wr(8'h2c, 32'h120);
    @(posedge core_clk);
    check("usr_cond", 32'h0, user_cond);
    check("usr_sum", 32'h1, user_summary);
    rd(8'h28, 32'h120);
    rd(8'h28, 32'h0);
    rd(8'h2c, 32'h0);
    wr(8'h2c, 32'hc000_0000);
    rd(8'h28, 32'h7fff);
    wr(8'h2c, 32'h20);
    pre();
    rd(8'h28, 32'h0);
    check("usr_sum", 32'h0, user_summary);
    finish_test();
  end
endmodule
